// ==== logic/tws_params.svh ====
// Constants for the two-wire serial port bus-condition and master-receive block
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_CLK_PERIOD_NS 20
`define TWS_RELOAD_W 8
`define TWS_BRG_PHASES 2
`define TWS_BITS_PER_BYTE 4'h8
`define TWS_BUF_DEPTH 2
`define TWS_RELOAD_MIN 8'h03
`define TWS_SLAVE_ADDR10 10'h000
`endif

// ==== logic/tws_pkg.sv ====
// Types for the two-wire serial port block
package tws_pkg;
    typedef enum logic [2:0] {
        TWS_IDLE = 3'h0,
        TWS_RX_LOW = 3'h1,
        TWS_RX_HIGH = 3'h2,
        TWS_RX_DONE = 3'h3,
        TWS_ACK_LOW = 3'h4,
        TWS_ACK_HIGH = 3'h5,
        TWS_ACK_END = 3'h6
    } tws_state_e;

    typedef enum logic [1:0] {
        TWS_SL_IDLE = 2'h0,
        TWS_SL_ADDR_HI = 2'h1,
        TWS_SL_ADDR_LO = 2'h2,
        TWS_SL_DATA = 2'h3
    } tws_slave_e;
endpackage

// ==== logic/tws_core.sv ====
// Two-wire serial port: bus condition detection and master byte reception
`timescale 1ns/1ns
`include "tws_params.svh"
module tws_core (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_scl_oe_n,
    output logic o_sda,
    output logic o_sda_oe_n,
    input wire logic [7:0] i_address_reload_register,
    input wire logic i_master_mode,
    input wire logic i_receive_enable_bit,
    input wire logic i_start_request,
    input wire logic i_ack_sequence_enable,
    input wire logic i_ack_data_value,
    input wire logic i_slave_irq_native,
    input wire logic i_start_detect_irq_enable,
    input wire logic i_stop_detect_irq_enable,
    input wire logic i_slave_ten_bit,
    input wire logic i_buffer_write,
    input wire logic i_interrupt_clear,
    input wire logic i_overflow_clear,
    input wire logic i_collision_clear,
    output logic [7:0] o_serial_data_buffer,
    output logic o_data_valid,
    input wire logic i_data_ready,
    output logic o_buffer_full_flag,
    output logic o_serial_interrupt_flag,
    output logic o_receive_overflow_flag,
    output logic o_write_collision_flag,
    output logic o_bus_collision,
    output logic o_bus_active,
    output logic o_start_seen,
    output logic o_stop_seen,
    output logic o_receive_busy,
    output logic o_prior_match
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_q;
        logic sda_q;
        logic scl_low_seen;
        tws_pkg::tws_state_e st;
        tws_pkg::tws_slave_e sl;
        logic [7:0] baud_rate_generator;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] buf0;
        logic [7:0] buf1;
        logic [1:0] count;
        logic rd_ptr;
        logic wr_ptr;
        logic scl_drv_low;
        logic sda_drv_low;
        logic bf;
        logic sif;
        logic ov;
        logic write_collision_flag;
        logic bcol;
        logic active;
        logic start_p;
        logic stop_p;
        logic prior;
        logic hi_ok;
        logic [7:0] slv_sh;
        logic [3:0] slv_cnt;
        logic receive_enable_bit_q;
        logic startreq_q;
        logic [7:0] dout;
        logic dv;
        logic busy;
    } tws_state_s;

    tws_state_s r;
    tws_state_s next_r;
    logic scl_s;
    logic sda_s;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic rollover;
    logic pop;
    logic push;
    logic [7:0] hi_addr;

    assign scl_s = r.scl_sync[1];
    assign sda_s = r.sda_sync[1];
    assign start_det = r.scl_q && scl_s && r.sda_q && !sda_s;
    assign stop_det = r.scl_q && scl_s && !r.sda_q && sda_s && r.scl_low_seen;
    assign scl_rise = !r.scl_q && scl_s;
    assign scl_fall = r.scl_q && !scl_s;
    assign rollover = (r.baud_rate_generator == 8'h00);
    assign pop = o_data_valid && i_data_ready;
    assign hi_addr = {5'h1E, 2'(`TWS_SLAVE_ADDR10 >> 8), 1'b0};

    always_comb begin
        next_r = r;
        next_r.start_p = 1'b0;
        next_r.stop_p = 1'b0;
        push = 1'b0;
        next_r.scl_sync = {r.scl_sync[0], i_scl};
        next_r.sda_sync = {r.sda_sync[0], i_sda};
        next_r.scl_q = scl_s;
        next_r.sda_q = sda_s;
        next_r.receive_enable_bit_q = i_receive_enable_bit;
        next_r.startreq_q = i_start_request;
        if (!scl_s) begin
            next_r.scl_low_seen = 1'b1;
        end
        if (start_det) begin
            next_r.active = 1'b1;
            next_r.scl_low_seen = 1'b0;
            next_r.sl = tws_pkg::TWS_SL_ADDR_HI;
            next_r.slv_cnt = 4'h0;
            next_r.start_p = 1'b1;
            if (!i_master_mode && !i_slave_irq_native && i_start_detect_irq_enable) begin
                next_r.sif = 1'b1;
            end
        end
        if (stop_det) begin
            next_r.active = 1'b0;
            next_r.sl = tws_pkg::TWS_SL_IDLE;
            next_r.prior = 1'b0;
            next_r.stop_p = 1'b1;
            if (!i_master_mode && !i_slave_irq_native && i_stop_detect_irq_enable) begin
                next_r.sif = 1'b1;
            end
        end
        // Slave address tracking for the 10-bit prior-match flag
        if (!start_det && !stop_det && r.sl != tws_pkg::TWS_SL_IDLE && scl_rise) begin
            next_r.slv_sh = {r.slv_sh[6:0], sda_s};
            next_r.slv_cnt = r.slv_cnt + 4'h1;
        end
        if (scl_fall && r.slv_cnt == `TWS_BITS_PER_BYTE && i_slave_ten_bit) begin
            // Ninth clock carries the acknowledge; it wraps the count to zero
            next_r.slv_cnt = 4'hF;
            if (r.sl == tws_pkg::TWS_SL_ADDR_HI) begin
                next_r.hi_ok = (r.slv_sh[7:1] == hi_addr[7:1]);
                if (r.slv_sh[7:1] != hi_addr[7:1] || !r.slv_sh[0]) begin
                    next_r.prior = 1'b0;
                end
                if (r.slv_sh[7:1] == hi_addr[7:1] && r.slv_sh[0] && r.prior) begin
                    next_r.sl = tws_pkg::TWS_SL_DATA;
                end else begin
                    next_r.sl = tws_pkg::TWS_SL_ADDR_LO;
                end
            end else if (r.sl == tws_pkg::TWS_SL_ADDR_LO) begin
                if (r.hi_ok && r.slv_sh == 8'(`TWS_SLAVE_ADDR10 & 10'h0FF)) begin
                    next_r.prior = 1'b1;
                end
                next_r.sl = tws_pkg::TWS_SL_DATA;
            end
        end
        // Master start generation with collision check
        if (i_start_request && !r.startreq_q && i_master_mode && !r.active) begin
            if (!sda_s) begin
                next_r.bcol = 1'b1;
            end else begin
                next_r.sda_drv_low = 1'b1;
            end
        end
        if (r.baud_rate_generator != 8'h00) begin
            next_r.baud_rate_generator = r.baud_rate_generator - 8'h01;
        end
        unique case (r.st)
            tws_pkg::TWS_IDLE: begin
                if (i_receive_enable_bit && !r.receive_enable_bit_q && i_master_mode) begin
                    next_r.st = tws_pkg::TWS_RX_LOW;
                    next_r.baud_rate_generator = i_address_reload_register;
                    next_r.bitcnt = 4'h0;
                    next_r.sda_drv_low = 1'b0;
                    next_r.scl_drv_low = 1'b1;
                end else if (i_ack_sequence_enable && r.scl_drv_low) begin
                    next_r.st = tws_pkg::TWS_ACK_LOW;
                    next_r.sda_drv_low = !i_ack_data_value;
                    next_r.baud_rate_generator = i_address_reload_register;
                end
            end
            tws_pkg::TWS_RX_LOW: begin
                if (rollover) begin
                    next_r.scl_drv_low = 1'b0;
                    next_r.baud_rate_generator = i_address_reload_register;
                    next_r.st = tws_pkg::TWS_RX_HIGH;
                end
            end
            tws_pkg::TWS_RX_HIGH: begin
                // Waits for SCL to really rise, so a stretching slave is honoured
                if (rollover && scl_s) begin
                    next_r.shreg = {r.shreg[6:0], sda_s};
                    next_r.bitcnt = r.bitcnt + 4'h1;
                    next_r.scl_drv_low = 1'b1;
                    next_r.baud_rate_generator = i_address_reload_register;
                    if (r.bitcnt == `TWS_BITS_PER_BYTE - 4'h1) begin
                        next_r.st = tws_pkg::TWS_RX_DONE;
                    end else begin
                        next_r.st = tws_pkg::TWS_RX_LOW;
                    end
                end
            end
            tws_pkg::TWS_RX_DONE: begin
                next_r.st = tws_pkg::TWS_IDLE;
                next_r.sif = 1'b1;
                if (r.bf) begin
                    next_r.ov = 1'b1;
                end
                if (r.count != 2'(`TWS_BUF_DEPTH)) begin
                    push = 1'b1;
                end
            end
            tws_pkg::TWS_ACK_LOW: begin
                if (rollover) begin
                    next_r.scl_drv_low = 1'b0;
                    next_r.baud_rate_generator = i_address_reload_register;
                    next_r.st = tws_pkg::TWS_ACK_HIGH;
                end
            end
            tws_pkg::TWS_ACK_HIGH: begin
                if (rollover && scl_s) begin
                    next_r.scl_drv_low = 1'b1;
                    next_r.baud_rate_generator = i_address_reload_register;
                    next_r.st = tws_pkg::TWS_ACK_END;
                end
            end
            tws_pkg::TWS_ACK_END: begin
                if (rollover) begin
                    next_r.sda_drv_low = 1'b0;
                    next_r.sif = 1'b1;
                    next_r.st = tws_pkg::TWS_IDLE;
                end
            end
            default: begin
                next_r.st = tws_pkg::TWS_IDLE;
            end
        endcase
        next_r.busy = (next_r.st != tws_pkg::TWS_IDLE);
        if (push) begin
            if (r.wr_ptr) begin
                next_r.buf1 = r.shreg;
            end else begin
                next_r.buf0 = r.shreg;
            end
            next_r.wr_ptr = !r.wr_ptr;
        end
        if (pop) begin
            next_r.rd_ptr = !r.rd_ptr;
        end
        next_r.count = r.count + 2'(push) - 2'(pop);
        next_r.dout = next_r.rd_ptr ? next_r.buf1 : next_r.buf0;
        next_r.dv = (next_r.count != 2'h0);
        // Set beats clear: a byte landing with the read keeps the flag up
        if (push) begin
            next_r.bf = 1'b1;
        end else if (pop) begin
            next_r.bf = (r.count == 2'h2);
        end
        if (i_buffer_write && r.st != tws_pkg::TWS_IDLE) begin
            next_r.write_collision_flag = 1'b1;
        end else if (i_collision_clear) begin
            next_r.write_collision_flag = 1'b0;
        end
        if (i_interrupt_clear && !(next_r.sif && !r.sif)) begin
            next_r.sif = 1'b0;
        end
        if (i_overflow_clear && !(next_r.ov && !r.ov)) begin
            next_r.ov = 1'b0;
        end
        if (i_start_request && !r.startreq_q && !sda_s && !r.active && i_master_mode) begin
            next_r.bcol = 1'b1;
        end else if (i_collision_clear) begin
            next_r.bcol = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
            r.scl_sync <= 2'h3;
            r.sda_sync <= 2'h3;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign o_serial_data_buffer = r.dout;
    assign o_data_valid = r.dv;
    assign o_scl = 1'b0;
    assign o_sda = 1'b0;
    assign o_scl_oe_n = !r.scl_drv_low;
    assign o_sda_oe_n = !r.sda_drv_low;
    assign o_buffer_full_flag = r.bf;
    assign o_serial_interrupt_flag = r.sif;
    assign o_receive_overflow_flag = r.ov;
    assign o_write_collision_flag = r.write_collision_flag;
    assign o_bus_collision = r.bcol;
    assign o_bus_active = r.active;
    assign o_start_seen = r.start_p;
    assign o_stop_seen = r.stop_p;
    assign o_receive_busy = r.busy;
    assign o_prior_match = r.prior;

    a_byte_flags: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == tws_pkg::TWS_RX_DONE |=> r.sif && r.bf && r.st == tws_pkg::TWS_IDLE)
        else $error("byte end flags missing");
    a_scl_held: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == tws_pkg::TWS_RX_DONE |=> !o_scl_oe_n)
        else $error("scl not held low");
    a_receive_enable_bit_busy: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_receive_enable_bit) && r.st == tws_pkg::TWS_IDLE && i_master_mode
        && !r.receive_enable_bit_q |=> r.st == tws_pkg::TWS_RX_LOW)
        else $error("receive did not start");
    a_receive_enable_bit_ignore: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == tws_pkg::TWS_RX_HIGH |=> r.st != tws_pkg::TWS_ACK_LOW)
        else $error("command taken while busy");
    a_overflow: assert property (@(posedge i_clk) disable iff (!i_resetn)
        r.st == tws_pkg::TWS_RX_DONE && r.bf |=> r.ov)
        else $error("overflow missed");
    a_write_collision_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_buffer_write && r.st != tws_pkg::TWS_IDLE |=> r.write_collision_flag)
        else $error("write collision missed");
    a_stop_bus: assert property (@(posedge i_clk) disable iff (!i_resetn)
        stop_det |=> !r.active && !r.prior && r.stop_p)
        else $error("stop not handled");
    a_start_bus: assert property (@(posedge i_clk) disable iff (!i_resetn)
        start_det |=> r.active && r.sl == tws_pkg::TWS_SL_ADDR_HI)
        else $error("start not handled");
    a_stop_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
        stop_det |-> r.scl_low_seen)
        else $error("stop without scl low");
    a_bf_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pop && !push && r.count == 2'h1 |=> !r.bf)
        else $error("buffer full not cleared");
    c_byte: cover property (@(posedge i_clk) r.st == tws_pkg::TWS_RX_DONE);
    c_ack: cover property (@(posedge i_clk) r.st == tws_pkg::TWS_ACK_END);
    c_stop: cover property (@(posedge i_clk) stop_det);
    c_ovf: cover property (@(posedge i_clk) $rose(r.ov));
endmodule // tws_core

// ==== tb/tws_slave_tx.sv ====
// Bus slave model that hands one byte to the master per armed read
`timescale 1ns/1ns
module tws_slave_tx (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_load,
    input wire logic i_slow,
    input wire logic [7:0] i_byte,
    output logic o_sda_low,
    output logic o_scl_low
);
    logic [7:0] shift;
    logic armed;
    logic scl_q;
    int cnt;
    int hold;
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            armed <= 1'b0;
            cnt <= 0;
            hold <= 0;
            o_sda_low <= 1'b0;
            o_scl_low <= 1'b0;
            scl_q <= 1'b1;
            shift <= 8'h00;
        end else begin
            scl_q <= i_scl;
            if (hold > 0) hold <= hold - 1;
            // Slow mode stretches the low phase of each of the 8 data bits so the master must wait for SCL
            o_scl_low <= (hold > 1);
            if (i_load) begin
                armed <= 1'b1;
                cnt <= 0;
                shift <= i_byte;
            end else if (armed && !i_scl && (scl_q || cnt == 0)) begin
                // Data only moves while SCL is low, so no false start or stop
                if (cnt < 8) begin
                    o_sda_low <= ~shift[7 - cnt];
                    cnt <= cnt + 1;
                    if (i_slow) hold <= 6;
                end else begin
                    o_sda_low <= 1'b0;
                    armed <= 1'b0;
                end
            end
        end
    end
endmodule // tws_slave_tx

// ==== tb/test_i2c_bus_conditions_master_receive.sv ====
// Self-checking bench for the bus-condition and master-receive block
`timescale 1ns/1ns
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, a); end end
`define WAITC(c, lim) begin wk = 0; while ((c) !== 1'b1 && wk < lim) begin \
    @(negedge i_clk); wk++; end if ((c) !== 1'b1) begin n_errors++; finish_test(); end end
`define PULSE(s) begin @(posedge i_clk); s <= 1'b1; @(posedge i_clk); s <= 1'b0; end
module test_i2c_bus_conditions_master_receive;
    logic i_clk = 1'b0, i_resetn = 1'b0, m_mode = 1'b0, receive_enable_bit = 1'b0, start_req = 1'b0;
    logic ack_en = 1'b0, ack_dt = 1'b0, native = 1'b0, st_en = 1'b0, sp_en = 1'b0;
    logic bwr = 1'b0, int_clr = 1'b0, ov_clr = 1'b0, col_clr = 1'b0, rdy = 1'b0;
    logic tb_scl_low = 1'b0, tb_sda_low = 1'b0, slow = 1'b0, load = 1'b0, exp_ov = 1'b0;
    logic [7:0] reload = 8'h03, sbyte = 8'h00, buf_q, popped;
    logic scl_oe_n, sda_oe_n, sl_sda, sl_scl, dv, bf, sif, ov, write_collision_flag, bcol, act, sts, sps;
    logic busy, ten = 1'b0, pm;
    wire scl = ~(~scl_oe_n | tb_scl_low | sl_scl);
    wire sda = ~(~sda_oe_n | tb_sda_low | sl_sda);
    int n_errors = 0, comparisons = 0, n_st = 0, n_sp = 0, pulled = 0, wk = 0, n0;
    logic [7:0] q[$];
    tws_core u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda),
        .o_scl(), .o_scl_oe_n(scl_oe_n), .o_sda(), .o_sda_oe_n(sda_oe_n),
        .i_address_reload_register(reload), .i_master_mode(m_mode),
        .i_receive_enable_bit(receive_enable_bit), .i_start_request(start_req),
        .i_ack_sequence_enable(ack_en), .i_ack_data_value(ack_dt),
        .i_slave_irq_native(native), .i_start_detect_irq_enable(st_en),
        .i_stop_detect_irq_enable(sp_en), .i_slave_ten_bit(ten), .i_buffer_write(bwr),
        .i_interrupt_clear(int_clr), .i_overflow_clear(ov_clr), .i_collision_clear(col_clr),
        .o_serial_data_buffer(buf_q), .o_data_valid(dv), .i_data_ready(rdy),
        .o_buffer_full_flag(bf), .o_serial_interrupt_flag(sif), .o_receive_overflow_flag(ov),
        .o_write_collision_flag(write_collision_flag), .o_bus_collision(bcol), .o_bus_active(act),
        .o_start_seen(sts), .o_stop_seen(sps), .o_receive_busy(busy), .o_prior_match(pm));
    tws_slave_tx u_slave (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_load(load),
        .i_slow(slow), .i_byte(sbyte), .o_sda_low(sl_sda), .o_scl_low(sl_scl));
    initial forever #10 i_clk = ~i_clk;
    // Event outputs are one-cycle pulses, so they are counted rather than sampled
    always @(posedge i_clk) begin
        if (sts === 1'b1) n_st++;
        if (sps === 1'b1) n_sp++;
        if (sda_oe_n === 1'b0) pulled++;
    end
    task finish_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task lines(input logic c, input logic d);
        @(posedge i_clk);
        tb_scl_low <= ~c;
        tb_sda_low <= ~d;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
    endtask
    // Clocks one byte and an acknowledge low through the bus lines by hand
    task sbyte_bits(input logic [7:0] b);
        for (int k = 7; k >= 0; k--) begin
            lines(1'b0, b[k]);
            lines(1'b1, b[k]);
        end
        lines(1'b0, 1'b0);
        lines(1'b1, 1'b0);
        lines(1'b0, 1'b0);
    endtask
    task rx(input logic [7:0] b, input logic mid);
        @(posedge i_clk);
        sbyte <= b;
        load <= 1'b1;
        @(posedge i_clk);
        load <= 1'b0;
        receive_enable_bit <= 1'b1;
        @(posedge i_clk);
        receive_enable_bit <= 1'b0;
        if (mid) begin
            repeat (8) @(posedge i_clk);
            receive_enable_bit <= 1'b1;
            bwr <= 1'b1;
            @(posedge i_clk);
            receive_enable_bit <= 1'b0;
            bwr <= 1'b0;
        end
        `WAITC(sif, 3000)
        if (q.size() > 0) exp_ov = 1'b1;
        if (q.size() < 2) q.push_back(b);
        if (!mid && !slow) `CHK("bit timing", 1'b1, wk >= 16 * (reload + 1) && wk <= 16 * (reload + 1) + 64)
        `CHK("busy", 1'b0, busy)
        `CHK("scl held low", 1'b0, scl_oe_n)
        `CHK("full", 1'b1, bf)
        `CHK("overflow", exp_ov, ov)
        `CHK("buffer head", q[0], buf_q)
        `CHK("write collision", mid, write_collision_flag)
        `PULSE(int_clr)
    endtask
    task pop();
        @(negedge i_clk);
        popped = q.pop_front();
        `CHK("valid", 1'b1, dv)
        `CHK("data", popped, buf_q)
        @(posedge i_clk);
        rdy <= 1'b1;
        @(posedge i_clk);
        rdy <= 1'b0;
        @(negedge i_clk);
        `CHK("full after read", q.size() > 0, bf)
    endtask
    task ack(input logic d);
        @(posedge i_clk);
        ack_dt <= d;
        ack_en <= 1'b1;
        pulled = 0;
        @(posedge i_clk);
        ack_en <= 1'b0;
        repeat (2) @(posedge i_clk);
        `WAITC(!busy, 3000)
        `CHK("ack level", ~d, pulled > 0)
        `PULSE(int_clr)
    endtask
    initial begin
        void'($urandom(272));
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        `CHK("idle bus", 1'b0, act)
        `CHK("scl released", 1'b1, scl_oe_n)
        lines(1'b1, 1'b0);
        lines(1'b1, 1'b1);
        `CHK("starts", 1, n_st)
        `CHK("no stop", 0, n_sp)
        lines(1'b0, 1'b1);
        lines(1'b1, 1'b1);
        lines(1'b1, 1'b0);
        `CHK("restart", 2, n_st)
        for (int i = 0; i < 3; i++) begin
            st_en <= (i != 1);
            sp_en <= (i != 1);
            native <= (i == 2);
            `PULSE(int_clr)
            lines(1'b0, 1'b0);
            lines(1'b1, 1'b0);
            lines(1'b1, 1'b1);
            `CHK("stop irq", i == 0, sif)
            `CHK("released", 1'b0, act)
            `PULSE(int_clr)
            lines(1'b1, 1'b0);
            `CHK("start irq", i == 0, sif)
            `CHK("active", 1'b1, act)
        end
        lines(1'b0, 1'b0);
        lines(1'b1, 1'b0);
        lines(1'b1, 1'b1);
        `CHK("stops", 4, n_sp)
        ten <= 1'b1;
        lines(1'b1, 1'b0);
        sbyte_bits({5'h1E, 2'h0, 1'b0});
        sbyte_bits(8'h00);
        `CHK("prior match", 1'b1, pm)
        lines(1'b1, 1'b0);
        lines(1'b1, 1'b1);
        `CHK("prior cleared", 1'b0, pm)
        ten <= 1'b0;
        m_mode <= 1'b1;
        lines(1'b0, 1'b1);
        lines(1'b0, 1'b0);
        `PULSE(start_req)
        repeat (6) @(negedge i_clk);
        `CHK("bus collision", 1'b1, bcol)
        lines(1'b0, 1'b1);
        lines(1'b1, 1'b1);
        `PULSE(col_clr)
        `PULSE(int_clr)
        for (int i = 0; i < 4; i++) begin
            reload <= 8'(3 + $urandom % 4);
            slow <= (i == 1);
            rx(8'($urandom), i == 1);
            if (i == 1) `PULSE(col_clr)
            if (i == 0) begin
                pop();
                ack(1'b0);
            end
        end
        pop();
        pop();
        `PULSE(ov_clr)
        exp_ov = 1'b0;
        @(negedge i_clk);
        `CHK("overflow cleared", 1'b0, ov)
        ack(1'b1);
        // Second reset mid-run leaves the bus idle with both lines high
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_clk);
        n0 = n_st;
        `PULSE(start_req)
        `WAITC(!sda_oe_n, 50)
        repeat (6) @(negedge i_clk);
        `CHK("own start", n0 + 1, n_st)
        `CHK("no collision", 1'b0, bcol)
        `CHK("active", 1'b1, act)
        finish_test();
    end
endmodule // test_i2c_bus_conditions_master_receive
